/* File: hdl/module_power_gate_pkg.sv */
// Constants for the peripheral module power gate block
package module_power_gate_pkg;
    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_REGS = 3;
    localparam int NUM_PERIPH = 13;
    // Byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFS_CTRL_0 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_1 = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CTRL_2 = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;
    // Reset value of every disable register
    localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
    // Implemented bits per register, all others read zero
    localparam logic [REG_W-1:0] CTRL_0_MASK = 8'hC7;
    localparam logic [REG_W-1:0] CTRL_1_MASK = 8'h87;
    localparam logic [REG_W-1:0] CTRL_2_MASK = 8'h67;
    // Field positions inside the flat 24-bit disable vector
    localparam int POS_SYSCLK_NET = 7;
    localparam int POS_VOLTAGE_REF = 6;
    localparam int POS_NONVOLATILE_MEM = 2;
    localparam int POS_CLOCK_REF_OUT = 1;
    localparam int POS_PIN_CHANGE_IRQ = 0;
    localparam int POS_NUM_OSC = 15;
    localparam int POS_TIMER_TWO = 10;
    localparam int POS_TIMER_ONE = 9;
    localparam int POS_TIMER_ZERO = 8;
    localparam int POS_ANALOG_OUT = 22;
    localparam int POS_ANALOG_IN = 21;
    localparam int POS_COMPARATOR_TWO = 18;
    localparam int POS_COMPARATOR_ONE = 17;
    localparam int POS_ZERO_CROSS = 16;
    // Peripheral slot order used on every per-module port
    localparam int PERIPH_POS [NUM_PERIPH] = '{
        POS_VOLTAGE_REF, POS_NONVOLATILE_MEM, POS_CLOCK_REF_OUT, POS_PIN_CHANGE_IRQ,
        POS_NUM_OSC, POS_TIMER_TWO, POS_TIMER_ONE, POS_TIMER_ZERO,
        POS_ANALOG_OUT, POS_ANALOG_IN, POS_COMPARATOR_TWO, POS_COMPARATOR_ONE,
        POS_ZERO_CROSS};
    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/module_power_gate.sv */
// Peripheral module power gate with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

// Contract
// R1: Any reset clears all disable bits.
// R2: Disabled module gets no clock or control.
// R3: Disabled module held reset, writes ignored, reads zero.
// R4: Clearing bit restarts module from reset state.
// R5: Software waits one instruction after re-enable.
// R6: Disable also disables module pin-map selections.
// R7: System clock bit stops peripheral clock network.
// R8: Register 0 bit layout, bits 5-3 zero.
// R9: Memory disable blocks memory and control access.
// R10: Software waits up to 1 us after memory enable.
// R11: Pin-change bit disables all ports together.
// R12: Register 1 bit layout, bits 6-3 zero.
// R13: Register 2 bit layout, bits 7,4,3 zero.
// R14: One disables module, zero enables it.
// R15: Clock gating glitch-free, switches only clock-low.
// R16: Unimplemented bits ignore writes, read zero.
module module_power_gate #(
    parameter int NUM_PERIPH = module_power_gate_pkg::NUM_PERIPH
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [module_power_gate_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [module_power_gate_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [module_power_gate_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [module_power_gate_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Gated clocks to the peripherals
    output logic sysclk_net_clk,
    output logic [NUM_PERIPH-1:0] periph_clk,
    // Per-module reset and pin-map enable
    output logic [NUM_PERIPH-1:0] periph_rst_n,
    output logic [NUM_PERIPH-1:0] pin_map_enable,
    // Memory access block level
    output logic nonvolatile_mem_block,
    // Core side access to peripheral registers
    input wire logic [NUM_PERIPH-1:0] sfr_sel,
    input wire logic sfr_we,
    input wire logic [NUM_PERIPH*8-1:0] sfr_rdata_in,
    output logic [NUM_PERIPH-1:0] sfr_we_out,
    output logic [7:0] sfr_rdata
);

    // Write channel state
    logic aw_held_r, aw_held_nxt;
    logic [module_power_gate_pkg::ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic w_held_r, w_held_nxt;
    logic [7:0] w_data_r, w_data_nxt; // Only the low byte is ever stored
    logic w_strb0_r, w_strb0_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;

    // Read channel state
    logic rvalid_r, rvalid_nxt;
    logic [module_power_gate_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    // Disable registers
    logic [7:0] ctrl_0_r, ctrl_0_nxt;
    logic [7:0] ctrl_1_r, ctrl_1_nxt;
    logic [7:0] ctrl_2_r, ctrl_2_nxt;
    logic [23:0] dis_vec; // Flat view, register 2 on top

    // Per-module reset and access gating
    logic [NUM_PERIPH-1:0] periph_dis;
    logic [NUM_PERIPH-1:0] run_r, run_nxt; // High while out of reset
    logic [7:0] sfr_rdata_r, sfr_rdata_nxt;

    // Clock gate enables, slot NUM_PERIPH is the system clock net
    logic [NUM_PERIPH:0] gate_en;
    logic [NUM_PERIPH:0] gate_lat;
    logic [NUM_PERIPH:0] gate_clk;

    logic do_write; // Both halves of a write are in hand

    // Handshakes: one write and one read in flight at most
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign do_write = aw_held_r && w_held_r;

    // Write path and disable register update
    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb0_nxt = w_strb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ctrl_0_nxt = ctrl_0_r;
        ctrl_1_nxt = ctrl_1_r;
        ctrl_2_nxt = ctrl_2_r;
        // Address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata[7:0];
            w_strb0_nxt = s_axi_wstrb[0];
        end
        // Commit one cycle after both halves are held
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = module_power_gate_pkg::RESP_OKAY;
            unique case (aw_addr_r)
                module_power_gate_pkg::OFS_CTRL_0: begin
                    // Reserved bits are masked off on the way in
                    if (w_strb0_r) begin
                        ctrl_0_nxt = w_data_r & module_power_gate_pkg::CTRL_0_MASK; // R8 R16
                    end
                end
                module_power_gate_pkg::OFS_CTRL_1: begin
                    if (w_strb0_r) begin
                        ctrl_1_nxt = w_data_r & module_power_gate_pkg::CTRL_1_MASK; // R12 R16
                    end
                end
                module_power_gate_pkg::OFS_CTRL_2: begin
                    if (w_strb0_r) begin
                        ctrl_2_nxt = w_data_r & module_power_gate_pkg::CTRL_2_MASK; // R13 R16
                    end
                end
                module_power_gate_pkg::OFS_STATUS: begin
                    // Read-only, write accepted and dropped
                    bresp_nxt = module_power_gate_pkg::RESP_OKAY;
                end
                default: begin
                    // Unmapped address
                    bresp_nxt = module_power_gate_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Response retires on bready
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // Write path registers, all clear on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= module_power_gate_pkg::RESP_OKAY;
            ctrl_0_r <= module_power_gate_pkg::CTRL_RESET; // R1
            ctrl_1_r <= module_power_gate_pkg::CTRL_RESET; // R1
            ctrl_2_r <= module_power_gate_pkg::CTRL_RESET; // R1
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb0_r <= w_strb0_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            ctrl_0_r <= ctrl_0_nxt;
            ctrl_1_r <= ctrl_1_nxt;
            ctrl_2_r <= ctrl_2_nxt;
        end
    end

    // Read path, answer one cycle after the address is taken
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = '0;
            rresp_nxt = module_power_gate_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                module_power_gate_pkg::OFS_CTRL_0: begin
                    rdata_nxt[7:0] = ctrl_0_r; // R8 R16
                end
                module_power_gate_pkg::OFS_CTRL_1: begin
                    rdata_nxt[7:0] = ctrl_1_r; // R12 R16
                end
                module_power_gate_pkg::OFS_CTRL_2: begin
                    rdata_nxt[7:0] = ctrl_2_r; // R13 R16
                end
                module_power_gate_pkg::OFS_STATUS: begin
                    // Which modules are out of reset right now
                    rdata_nxt[NUM_PERIPH-1:0] = run_r;
                end
                default: begin
                    rresp_nxt = module_power_gate_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Read path registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= module_power_gate_pkg::RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign dis_vec = {ctrl_2_r, ctrl_1_r, ctrl_0_r};

    // Per-slot disable pick and clock gate enable
    generate
        for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_slot
            // A set bit means disabled, a clear bit means running
            assign periph_dis[i] = dis_vec[module_power_gate_pkg::PERIPH_POS[i]]; // R14
            assign gate_en[i] = !periph_dis[i]; // R2
        end
    endgenerate

    // System clock net shares the same gate style
    assign gate_en[NUM_PERIPH] = !dis_vec[module_power_gate_pkg::POS_SYSCLK_NET]; // R7

    // Latch-based gates: enable only follows while the clock is low,
    // so a change mid-pulse can never chop a high phase short
    generate
        for (genvar g = 0; g <= NUM_PERIPH; g++) begin : g_gate
            always_latch begin
                if (!aclk) begin
                    gate_lat[g] <= gate_en[g]; // R15
                end
            end
            assign gate_clk[g] = aclk & gate_lat[g]; // R15
        end
    endgenerate

    assign periph_clk = gate_clk[NUM_PERIPH-1:0]; // R2
    assign sysclk_net_clk = gate_clk[NUM_PERIPH]; // R7

    // Module reset follows the disable bit one edge later; on
    // re-enable the clock already runs while reset is still held,
    // so the module starts from a clean power-on state
    always_comb begin
        run_nxt = ~periph_dis; // R3 R4
    end

    // Modules sit in reset during system reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_r <= '0;
        end else begin
            run_r <= run_nxt;
        end
    end

    assign periph_rst_n = run_r; // R3 R4
    // Pin-map selections live and die with their module
    assign pin_map_enable = run_r; // R6
    // Whole memory path blocked by its disable bit
    assign nonvolatile_mem_block = dis_vec[module_power_gate_pkg::POS_NONVOLATILE_MEM]; // R9
    // Write strobes only reach modules out of reset; pin-change slot
    // covers every port through this single gate
    assign sfr_we_out = {NUM_PERIPH{sfr_we}} & sfr_sel & run_r; // R3 R9 R11

    // Read-back mux, disabled modules contribute zero
    always_comb begin
        sfr_rdata_nxt = 8'h00;
        for (int k = 0; k < NUM_PERIPH; k++) begin
            if (sfr_sel[k] && run_r[k]) begin
                sfr_rdata_nxt = sfr_rdata_nxt | sfr_rdata_in[k*8 +: 8]; // R3 R9
            end
        end
    end

    // Registered read data toward the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sfr_rdata_r <= 8'h00;
        end else begin
            sfr_rdata_r <= sfr_rdata_nxt;
        end
    end

    assign sfr_rdata = sfr_rdata_r;

endmodule

/* File: tb/module_power_gate_properties.sv */
// Port checker for the power gate, bound into the design
`timescale 1ns/1ps
module module_power_gate_properties #(
    parameter int NUM_PERIPH = 13
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channel handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // Per-slot control
    input wire logic [NUM_PERIPH-1:0] periph_rst_n,
    input wire logic [NUM_PERIPH-1:0] pin_map_enable,
    input wire logic nonvolatile_mem_block,
    // Core side register access
    input wire logic [NUM_PERIPH-1:0] sfr_sel,
    input wire logic sfr_we,
    input wire logic [NUM_PERIPH-1:0] sfr_we_out,
    input wire logic [7:0] sfr_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write halves taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Commit edge, then the response
    sequence wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    AST_RESET_CLEARS: assert property (disable iff (1'b0) !aresetn |=>
        periph_rst_n == '0 && pin_map_enable == '0 && !nonvolatile_mem_block) else $error("reset state wrong");
    AST_RELEASE_ALL: assert property ($rose(aresetn) |=> &periph_rst_n) else $error("slots not released");
    AST_WRITE_GATED: assert property (sfr_we_out == (sfr_we ? (sfr_sel & periph_rst_n) : '0))
        else $error("write reached a held slot");
    AST_READ_ZERO: assert property ((sfr_sel & periph_rst_n) == '0 |=> sfr_rdata == 8'h00)
        else $error("held slot read nonzero");
    AST_PINMAP_FOLLOWS: assert property (pin_map_enable == periph_rst_n) else $error("pin map mismatch");
    // Slot 1 is the memory slot
    AST_MEM_BLOCK_RESETS: assert property ($rose(nonvolatile_mem_block) |=> !periph_rst_n[1])
        else $error("memory slot not held");
    AST_MEM_UNBLOCK: assert property ($fell(nonvolatile_mem_block) |=> periph_rst_n[1])
        else $error("memory slot not released");
    AST_WRITE_COMMIT: assert property (wr_taken |=> wr_answer) else $error("write answer late");
endmodule
bind module_power_gate module_power_gate_properties #(.NUM_PERIPH(NUM_PERIPH)) chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .periph_rst_n,
    .pin_map_enable, .nonvolatile_mem_block, .sfr_sel, .sfr_we, .sfr_we_out, .sfr_rdata);

/* File: tb/periph_model.sv */
// Behavioural peripherals behind the gated clocks
`timescale 1ns/1ps
module periph_model #(
    parameter int N = 13,
    // Arbitrary nonzero power-on content, so zero reads come from the gate
    parameter logic [7:0] POR = 8'hA0
) (
    // Gated clocks and resets
    input wire logic sysclk_net_clk,
    input wire logic [N-1:0] periph_clk,
    input wire logic [N-1:0] periph_rst_n,
    // Register contents and clock edge counts
    output logic [N*8-1:0] sfr_rdata_in,
    output logic [N*8-1:0] edge_cnt,
    output logic [7:0] sys_edges
);
    initial sys_edges = 8'h00;
    // Edges seen on the network clock
    always @(posedge sysclk_net_clk) sys_edges <= sys_edges + 8'h01;
    for (genvar k = 0; k < N; k++) begin : g_slot
        logic [7:0] state_r = POR;
        logic [7:0] edges_r = 8'h00;
        // Reset is asynchronous here since the clock may stand still
        always @(posedge periph_clk[k] or negedge periph_rst_n[k]) begin
            if (!periph_rst_n[k]) begin
                state_r <= POR;
            end else begin
                state_r <= state_r + 8'h01;
            end
        end
        // Never reset, so a stopped clock shows as a frozen count
        always @(posedge periph_clk[k]) edges_r <= edges_r + 8'h01;
        assign sfr_rdata_in[k*8 +: 8] = state_r;
        assign edge_cnt[k*8 +: 8] = edges_r;
    end
endmodule

/* File: tb/module_power_gate_bench.sv */
// Self-checking bench of the peripheral power gate
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module module_power_gate_bench;
    localparam int NP = module_power_gate_pkg::NUM_PERIPH;
    localparam logic [7:0] POR = 8'hA0; // Model power-on content
    // Bench driven inputs
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sfr_we = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [NP-1:0] sfr_sel = '0;
    // Design and model outputs
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sysclk_net_clk;
    logic nonvolatile_mem_block;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [NP-1:0] periph_clk, periph_rst_n, pin_map_enable, sfr_we_out;
    logic [7:0] sfr_rdata, sys_edges;
    logic [NP*8-1:0] sfr_rdata_in, edge_cnt;
    int mismatches = 0;
    int n_tests = 0;
    module_power_gate #(.NUM_PERIPH(NP)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sysclk_net_clk, .periph_clk, .periph_rst_n, .pin_map_enable,
        .nonvolatile_mem_block, .sfr_sel, .sfr_we, .sfr_rdata_in, .sfr_we_out, .sfr_rdata);
    periph_model #(.N(NP), .POR(POR)) model (.sysclk_net_clk, .periph_clk, .periph_rst_n, .sfr_rdata_in, .edge_cnt,
        .sys_edges);
    // 250 MHz clock
    initial forever #2 aclk = ~aclk;
    // Verdict and end of run
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Write: both halves offered together, bready held until the answer
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        // Fresh edge, so a back-to-back call never reassigns bready in one step
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) begin mismatches++; complete_run(); end
        `CHK(s_axi_bresp, module_power_gate_pkg::RESP_OKAY)
    endtask
    // Read: data and response taken at the rvalid edge
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        // Fresh edge, so a back-to-back call never reassigns rready in one step
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) begin mismatches++; complete_run(); end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        `CHK(d, e)
        `CHK(r, module_power_gate_pkg::RESP_OKAY)
    endtask
    // Masks of the three registers, all slots held at once
    task automatic t_masks;
        for (int i = 0; i < 3; i++) axi_wr(4'(i * 4), 32'hFFFF_FFFF);
        rd_chk(module_power_gate_pkg::OFS_CTRL_0, 32'h0000_00C7);
        rd_chk(module_power_gate_pkg::OFS_CTRL_1, 32'h0000_0087);
        rd_chk(module_power_gate_pkg::OFS_CTRL_2, 32'h0000_0067);
        rd_chk(module_power_gate_pkg::OFS_STATUS, 32'h0000_0000);
        for (int i = 0; i < 3; i++) axi_wr(4'(i * 4), 32'h0000_0000);
    endtask
    // One slot disabled, probed, then re-enabled
    task automatic t_slot(input int k);
        int p;
        logic [7:0] e;
        p = module_power_gate_pkg::PERIPH_POS[k];
        axi_wr(4'(p / 8 * 4), 32'(1) << (p % 8));
        cyc(3);
        e = edge_cnt[k*8 +: 8];
        `CHK(sfr_rdata_in[k*8 +: 8], POR)
        cyc(5);
        `CHK(edge_cnt[k*8 +: 8], e)
        sfr_sel <= NP'(1) << k;
        sfr_we <= 1'b1;
        @(posedge aclk);
        `CHK(sfr_we_out, NP'(0))
        @(posedge aclk);
        `CHK(sfr_rdata, 8'h00)
        sfr_we <= 1'b0;
        `CHK(nonvolatile_mem_block, k == 1)
        `CHK(pin_map_enable[k], 1'b0)
        rd_chk(module_power_gate_pkg::OFS_STATUS, 32'h0000_1FFF & ~(32'(1) << k));
        axi_wr(4'(p / 8 * 4), 32'h0000_0000);
        cyc(2);
        `CHK(periph_rst_n[k], 1'b1)
        `CHK(8'(sfr_rdata_in[k*8 +: 8] - POR) < 8'h08, 1'b1)
        `CHK(sfr_rdata != 8'h00, 1'b1)
        // Memory slot gets its settling time after its read-back check, before the next slot
        if (k == 1) cyc(250);
        sfr_sel <= '0;
    endtask
    // Network clock stops, slot 0 clock and all slot resets untouched
    task automatic t_sysclk;
        logic [7:0] e;
        logic [7:0] s;
        axi_wr(module_power_gate_pkg::OFS_CTRL_0, 32'h0000_0080);
        cyc(3);
        e = sys_edges;
        s = edge_cnt[7:0];
        cyc(5);
        `CHK(sys_edges, e)
        `CHK(edge_cnt[7:0] - s, 8'h05)
        rd_chk(module_power_gate_pkg::OFS_STATUS, 32'h0000_1FFF);
        axi_wr(module_power_gate_pkg::OFS_CTRL_0, 32'h0000_0000);
    endtask
    // Read-only status write and an unaligned, unmapped read
    task automatic t_bus_edges;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(module_power_gate_pkg::OFS_STATUS, 32'h0000_0000);
        rd_chk(module_power_gate_pkg::OFS_STATUS, 32'h0000_1FFF);
        axi_rd(4'h2, d, r);
        `CHK(r, module_power_gate_pkg::RESP_SLVERR)
        `CHK(d, 32'h0000_0000)
        // Write with byte lane 0 off leaves the register alone
        s_axi_wstrb <= 4'h0;
        axi_wr(module_power_gate_pkg::OFS_CTRL_0, 32'h0000_0041);
        s_axi_wstrb <= 4'hF;
        rd_chk(module_power_gate_pkg::OFS_CTRL_0, 32'h0000_0000);
    endtask
    // Reset in mid-run clears a set register
    task automatic t_mid_reset;
        axi_wr(module_power_gate_pkg::OFS_CTRL_1, 32'h0000_0087);
        aresetn <= 1'b0;
        cyc(5);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(module_power_gate_pkg::OFS_CTRL_1, 32'h0000_0000);
        rd_chk(module_power_gate_pkg::OFS_STATUS, 32'h0000_1FFF);
    endtask
    initial begin
        cyc(5);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 3; i++) rd_chk(4'(i * 4), 32'h0000_0000);
        t_masks();
        for (int k = 0; k < NP; k++) t_slot(k);
        t_sysclk();
        t_bus_edges();
        t_mid_reset();
        complete_run();
    end
endmodule
